// ===== core/light_alert_pkg.sv
// shared field layout, reset values and codes of the sensor configuration register
package light_alert_pkg;

  // ----------------------------------------------------------------
  // register width and field positions
  // ----------------------------------------------------------------
  localparam int CFG_WIDTH = 16;
  localparam int RN_MSB = 15;
  localparam int RN_LSB = 12;
  localparam int CT_POS = 11;
  localparam int MODE_MSB = 10;
  localparam int MODE_LSB = 9;
  localparam int OVF_POS = 8;
  localparam int CRF_POS = 7;
  localparam int FH_POS = 6;
  localparam int FL_POS = 5;
  localparam int LATCH_POS = 4;
  localparam int POL_POS = 3;
  localparam int ME_POS = 2;
  localparam int FC_MSB = 1;
  localparam int FC_LSB = 0;

  // ----------------------------------------------------------------
  // result word layout: exponent over mantissa
  // ----------------------------------------------------------------
  localparam int EXP_WIDTH = 4;
  localparam int MANT_WIDTH = 12;
  localparam logic [3:0] EXP_MASKED = 4'h0;

  // ----------------------------------------------------------------
  // codes
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [3:0] RN_AUTO = 4'hc;
  localparam logic [1:0] FC_ONE = 2'h0;
  localparam logic [1:0] FC_TWO = 2'h1;
  localparam logic [1:0] FC_FOUR = 2'h2;
  localparam logic [1:0] FC_EIGHT = 2'h3;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [3:0] RN_RESET = 4'hc;
  localparam logic CT_RESET = 1'b1;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic LATCH_RESET = 1'b1;
  localparam logic POL_RESET = 1'b0;
  localparam logic ME_RESET = 1'b0;
  localparam logic [1:0] FC_RESET = 2'h0;
  localparam logic [15:0] RESULT_RESET = 16'h0000;

  // consecutive fault events needed for each fault-count code
  function automatic logic [3:0] faultTarget(input logic [1:0] fc);
    case (fc)
      FC_ONE: faultTarget = 4'h1;
      FC_TWO: faultTarget = 4'h2;
      FC_FOUR: faultTarget = 4'h4;
      default: faultTarget = 4'h8;
    endcase
  endfunction

endpackage

// ===== core/lux_compare.sv
// magnitude compare of two exponent/mantissa light values on a common lux scale
`timescale 1ns/10ps
`default_nettype none
module lux_compare #(
  parameter int EW = 4,
  parameter int MW = 12
) (
  input wire logic [EW-1:0] aExp,
  input wire logic [MW-1:0] aMant,
  input wire logic [EW-1:0] bExp,
  input wire logic [MW-1:0] bMant,
  output logic aGreater,
  output logic aLess
);
  localparam int LW = MW + (1 << EW) - 1;

  initial begin
    if (EW < 1 || EW > 5 || MW < 1) begin
      $error("lux_compare: unsupported widths");
    end
  end

  logic [LW-1:0] aLux;
  logic [LW-1:0] bLux;

  // both sides are widened before the shift so no bits fall off the top
  always_comb begin
    aLux = LW'(aMant) << aExp;
    bLux = LW'(bMant) << bExp;
    aGreater = aLux > bLux;
    aLess = aLux < bLux;
  end
endmodule // lux_compare
`default_nettype wire

// ===== core/fault_counter.sv
// consecutive out-of-limit counter for one threshold
`timescale 1ns/10ps
`default_nettype none
module fault_counter #(
  parameter int CW = 4
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic sample,
  input wire logic outOfLimit,
  input wire logic [CW-1:0] target,
  output logic hit
);
  initial begin
    if (CW < 4) begin
      $error("fault_counter: count width must hold eight");
    end
  end

  logic [CW-1:0] countQ;
  logic [CW-1:0] countD;
  logic [CW-1:0] countInc;

  // saturating count; a result back inside the limit starts it over
  always_comb begin
    countInc = (countQ == {CW{1'b1}}) ? countQ : countQ + CW'(1);
    countD = countQ;
    hit = 1'b0;
    if (sample) begin
      if (outOfLimit) begin
        countD = countInc;
        hit = countInc >= target;
      end else begin
        countD = '0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      countQ <= '0;
    end else begin
      countQ <= countD;
    end
  end
endmodule // fault_counter
`default_nettype wire

// ===== core/light_sensor_alert_config.sv
// configuration register, threshold flags and alert pin of the light sensor
`timescale 1ns/10ps
`default_nettype none
module light_sensor_alert_config
  import light_alert_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [light_alert_pkg::CFG_WIDTH-1:0] regWdata,
  output logic [light_alert_pkg::CFG_WIDTH-1:0] regRdata,
  output logic regRvalid,
  input wire logic convDone,
  input wire logic [light_alert_pkg::EXP_WIDTH-1:0] convExp,
  input wire logic [light_alert_pkg::MANT_WIDTH-1:0] convMant,
  input wire logic convOverflow,
  input wire logic [15:0] highLimit,
  input wire logic [15:0] lowLimit,
  output logic [15:0] resultOut,
  output logic [1:0] modeOut,
  output logic convTimeOut,
  output logic [3:0] rangeOut,
  output logic alertOut,
  output logic alertOe
);
  import light_alert_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [3:0] rnQ, rnD;
  logic ctQ, ctD;
  logic [1:0] modeQ, modeD;
  logic latchQ, latchD;
  logic polQ, polD;
  logic meQ, meD;
  logic [1:0] fcQ, fcD;
  logic ovfQ, ovfD;
  logic crfQ, crfD;
  logic fhQ, fhD;
  logic flQ, flD;
  logic [15:0] resultQ, resultD;
  logic [15:0] rdataQ, rdataD;
  logic rvalidQ, rvalidD;

  logic aboveRaw, belowRaw;
  logic highHit, lowHit;
  logic [3:0] target;
  logic [CFG_WIDTH-1:0] cfgView;
  logic alertActive;

  // ----------------------------------------------------------------
  // threshold comparison on the raw result
  // ----------------------------------------------------------------
  // the raw conversion feeds the compare, never the masked copy
  lux_compare #(.EW(EXP_WIDTH), .MW(MANT_WIDTH)) highCmp (
    .aExp(convExp),
    .aMant(convMant),
    .bExp(highLimit[15:12]),
    .bMant(highLimit[11:0]),
    .aGreater(aboveRaw),
    .aLess()
  );

  lux_compare #(.EW(EXP_WIDTH), .MW(MANT_WIDTH)) lowCmp (
    .aExp(convExp),
    .aMant(convMant),
    .bExp(lowLimit[15:12]),
    .bMant(lowLimit[11:0]),
    .aGreater(),
    .aLess(belowRaw)
  );

  assign target = faultTarget(fcQ);

  // one counter per threshold, cleared by any in-limit result
  fault_counter #(.CW(4)) highCount (
    .clock(clock),
    .rst(rst),
    .sample(convDone),
    .outOfLimit(aboveRaw),
    .target(target),
    .hit(highHit)
  );

  fault_counter #(.CW(4)) lowCount (
    .clock(clock),
    .rst(rst),
    .sample(convDone),
    .outOfLimit(belowRaw),
    .target(target),
    .hit(lowHit)
  );

  // ----------------------------------------------------------------
  // configuration fields and mode
  // ----------------------------------------------------------------
  // a host write wins over the single-shot return to shutdown
  always_comb begin
    rnD = rnQ;
    ctD = ctQ;
    modeD = modeQ;
    latchD = latchQ;
    polD = polQ;
    meD = meQ;
    fcD = fcQ;
    ovfD = convDone ? convOverflow : ovfQ;
    if (convDone && modeQ == MODE_SINGLE) begin
      modeD = MODE_SHUTDOWN;
    end
    if (regWrite) begin
      rnD = regWdata[RN_MSB:RN_LSB];
      ctD = regWdata[CT_POS];
      modeD = regWdata[MODE_MSB:MODE_LSB];
      latchD = regWdata[LATCH_POS];
      polD = regWdata[POL_POS];
      meD = regWdata[ME_POS];
      fcD = regWdata[FC_MSB:FC_LSB];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rnQ <= RN_RESET;
      ctQ <= CT_RESET;
      modeQ <= MODE_RESET;
      latchQ <= LATCH_RESET;
      polQ <= POL_RESET;
      meQ <= ME_RESET;
      fcQ <= FC_RESET;
      ovfQ <= 1'b0;
    end else begin
      rnQ <= rnD;
      ctQ <= ctD;
      modeQ <= modeD;
      latchQ <= latchD;
      polQ <= polD;
      meQ <= meD;
      fcQ <= fcD;
      ovfQ <= ovfD;
    end
  end

  // ----------------------------------------------------------------
  // reporting flags
  // ----------------------------------------------------------------
  // set wins over clear so a conversion landing on a read is not lost;
  // a write of any mode but shutdown clears the ready flag; the threshold flags ignore mode, so shutdown keeps them
  always_comb begin
    crfD = crfQ;
    if (regRead || (regWrite && regWdata[MODE_MSB:MODE_LSB] != MODE_SHUTDOWN)) begin
      crfD = 1'b0;
    end
    if (convDone) begin
      crfD = 1'b1;
    end
    fhD = fhQ;
    flD = flQ;
    if (latchQ) begin
      // latched style: only a configuration read clears
      if (regRead) begin
        fhD = 1'b0;
        flD = 1'b0;
      end
      if (highHit) begin
        fhD = 1'b1;
      end
      if (lowHit) begin
        flD = 1'b1;
      end
    end else if (convDone) begin
      // transparent style: a pending fault keeps the flag as it was
      fhD = highHit | (aboveRaw & fhQ);
      flD = lowHit | (belowRaw & flQ);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      crfQ <= 1'b0;
      fhQ <= 1'b0;
      flQ <= 1'b0;
    end else begin
      crfQ <= crfD;
      fhQ <= fhD;
      flQ <= flD;
    end
  end

  // ----------------------------------------------------------------
  // reported result and read port
  // ----------------------------------------------------------------
  assign cfgView = {rnQ, ctQ, modeQ, ovfQ, crfQ, fhQ, flQ, latchQ, polQ, meQ, fcQ};

  // read data is the value before the read's own clearing takes effect
  always_comb begin
    resultD = resultQ;
    if (convDone) begin
      resultD = {convExp, convMant};
      if (meQ && rnQ < RN_AUTO) begin
        resultD[15:12] = EXP_MASKED;
      end
    end
    rvalidD = regRead;
    rdataD = regRead ? cfgView : rdataQ;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      resultQ <= RESULT_RESET;
      rdataQ <= '0;
      rvalidQ <= 1'b0;
    end else begin
      resultQ <= resultD;
      rdataQ <= rdataD;
      rvalidQ <= rvalidD;
    end
  end

  // ----------------------------------------------------------------
  // alert pin, open drain: the output value is always low
  // ----------------------------------------------------------------
  assign alertActive = fhQ | flQ;
  assign alertOut = 1'b0;
  assign alertOe = polQ ? ~alertActive : alertActive;

  assign regRdata = rdataQ;
  assign regRvalid = rvalidQ;
  assign resultOut = resultQ;
  assign modeOut = modeQ;
  assign convTimeOut = ctQ;
  assign rangeOut = rnQ;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  crf_set_a: assert property (@(posedge clock) disable iff (rst)
    convDone |=> crfQ && $past(crfQ, 1) == 1'b0 || crfQ)
    else $error("ready flag not set after conversion");

  crf_clear_a: assert property (@(posedge clock) disable iff (rst)
    (regRead && !convDone) |=> !crfQ)
    else $error("ready flag not cleared by read");

  crf_shutdown_a: assert property (@(posedge clock) disable iff (rst)
    (regWrite && regWdata[MODE_MSB:MODE_LSB] == MODE_SHUTDOWN && !regRead && !convDone)
      |=> crfQ == $past(crfQ))
    else $error("shutdown write changed ready flag");

  high_trigger_a: assert property (@(posedge clock) disable iff (rst)
    (convDone && aboveRaw && fcQ == FC_ONE) |=> fhQ)
    else $error("high flag missed a single fault");

  low_trigger_a: assert property (@(posedge clock) disable iff (rst)
    (convDone && belowRaw && fcQ == FC_ONE) |=> flQ)
    else $error("low flag missed a single fault");

  // a fault that still leaves the run short of the target must not raise the flag
  fault_wait_a: assert property (@(posedge clock) disable iff (rst)
    (!fhQ && convDone && aboveRaw && highCount.countQ < target - 4'h1) |=> !fhQ)
    else $error("high flag set before fault count");

  transparent_clear_a: assert property (@(posedge clock) disable iff (rst)
    (!latchQ && convDone && !aboveRaw && !belowRaw) |=> !fhQ && !flQ)
    else $error("transparent flags did not follow comparison");

  latched_hold_a: assert property (@(posedge clock) disable iff (rst)
    (latchQ && !regWrite && (fhQ || flQ) && !regRead) |=> (fhQ || flQ))
    else $error("latched flag dropped without clearing read");

  alert_pol_a: assert property (@(posedge clock) disable iff (rst)
    (!polQ && $rose(alertActive)) |-> alertOe && !alertOut)
    else $error("active low alert not driven");

  alert_release_a: assert property (@(posedge clock) disable iff (rst)
    (polQ && alertActive) |-> !alertOe)
    else $error("active high alert still driven");

  mask_exp_a: assert property (@(posedge clock) disable iff (rst)
    (convDone && meQ && rnQ < RN_AUTO) |=> resultOut[15:12] == EXP_MASKED)
    else $error("exponent not masked under manual range");

  single_done_a: assert property (@(posedge clock) disable iff (rst)
    (convDone && modeQ == MODE_SINGLE && !regWrite) |=> modeQ == MODE_SHUTDOWN)
    else $error("single shot did not return to shutdown");

endmodule // light_sensor_alert_config
`default_nettype wire

// ===== verification/cfg_host_model.sv
// host-side model: configuration register strobes and the pulled-up alert line
`timescale 1ns/10ps
`default_nettype none
module cfg_host_model (
  input wire logic clock,
  output logic regWrite,
  output logic regRead,
  output logic [15:0] regWdata,
  input wire logic [15:0] regRdata,
  input wire logic regRvalid,
  input wire logic alertOut,
  input wire logic alertOe,
  output logic alertPin
);
  // open-drain line: the pull-up wins whenever the device lets go
  assign alertPin = alertOe ? alertOut : 1'b1;

  // idle bus at time zero
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regWdata = 16'h0000;
  end

  // one-word write; data turns to junk after the strobe so stale data cannot pass
  task automatic wr(input logic [15:0] w);
    @(posedge clock);
    regWrite <= 1'b1;
    regWdata <= w;
    @(posedge clock);
    regWrite <= 1'b0;
    regWdata <= ~w;
  endtask

  // one-word read; data taken at the edge where valid is seen, bounded wait
  task automatic rd(output logic [15:0] r, output logic ok);
    int n;
    @(posedge clock);
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    ok = 1'b0;
    r = 16'h0000;
    for (n = 0; n < 4 && !ok; n++) begin
      @(posedge clock);
      ok = (regRvalid === 1'b1);
      r = regRdata;
    end
  endtask
endmodule // cfg_host_model
`default_nettype wire

// ===== verification/tb_light_sensor_alert_config.sv
// self-checking bench for the configuration flags, fault counting and alert pin
`timescale 1ns/10ps
`default_nettype none
module tb_light_sensor_alert_config;
  import light_alert_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic regWrite, regRead, regRvalid, alertOut, alertOe, alertPin, convTimeOut;
  logic [15:0] regWdata, regRdata, resultOut;
  logic [15:0] highLimit = 16'h0800;
  logic [15:0] lowLimit = 16'h0100;
  logic convDone = 1'b0;
  logic convOverflow = 1'b0;
  logic ovfSeen = 1'b0;
  logic [3:0] convExp = 4'h0;
  logic [11:0] convMant = 12'h000;
  logic [1:0] modeOut;
  logic [3:0] rangeOut;
  int fails = 0;
  int nCompared = 0;

  // 40 MHz
  always #12.5 clock = ~clock;

  light_sensor_alert_config dut (.clock(clock), .rst(rst), .regWrite(regWrite),
    .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid),
    .convDone(convDone), .convExp(convExp), .convMant(convMant),
    .convOverflow(convOverflow), .highLimit(highLimit), .lowLimit(lowLimit),
    .resultOut(resultOut), .modeOut(modeOut), .convTimeOut(convTimeOut),
    .rangeOut(rangeOut), .alertOut(alertOut), .alertOe(alertOe));
  cfg_host_model host (.clock(clock), .regWrite(regWrite), .regRead(regRead),
    .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid),
    .alertOut(alertOut), .alertOe(alertOe), .alertPin(alertPin));

  // ----
  // expectation helpers
  // ----
  function automatic logic [26:0] luxOf(input logic [15:0] v);
    luxOf = {15'h0, v[11:0]} << v[15:12];
  endfunction
  // read-back view: written fields plus status flags, overflow as the last conversion left it
  function automatic logic [15:0] view(input logic [15:0] w, input logic conversion_ready_flag, fh, fl);
    view = {w[15:9], ovfSeen, conversion_ready_flag, fh, fl, w[4:0]};
  endfunction
  // random result: 2 above high limit, 1 inside, 0 below low limit
  function automatic logic [15:0] pick(input int side);
    case (side)
      2: pick = {4'($urandom_range(3, 1)), 12'($urandom_range(4095, 2048))};
      1: pick = {4'h0, 12'($urandom_range(2047, 512))};
      default: pick = {4'h0, 12'($urandom_range(255, 0))};
    endcase
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    nCompared++;
    if (got !== want) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic conv(input logic [15:0] v);
    logic o;
    o = 1'($urandom_range(1, 0));
    @(posedge clock);
    convDone <= 1'b1;
    convExp <= v[15:12];
    convMant <= v[11:0];
    convOverflow <= o;
    ovfSeen = o;
    @(posedge clock);
    convDone <= 1'b0;
    convExp <= ~v[15:12];
    convMant <= ~v[11:0];
    convOverflow <= ~o;
  endtask
  task automatic rdChk(input logic [15:0] want);
    logic [15:0] r;
    logic ok;
    host.rd(r, ok);
    chk({15'h0, ok}, 16'h0001);
    chk(r, want);
  endtask
  // let the last edge's updates land before looking at the pin
  task automatic pinChk(input logic want);
    #1;
    chk({15'h0, alertPin}, {15'h0, want});
  endtask

  // transparent run: one short of the count, an equal-to-limit restart, then the count
  task automatic faultRun(input logic [15:0] cfg, input int side);
    int k;
    logic hi;
    logic lo;
    hi = (side == 2);
    lo = (side == 0);
    conv(pick(1));
    for (k = 1; k < (1 << cfg[1:0]); k++) conv(pick(side));
    conv(hi ? 16'h1400 : 16'h2040); // equal to the limit under another exponent
    for (k = 1; k < (1 << cfg[1:0]); k++) conv(pick(side));
    rdChk(view(cfg, 1'b1, 1'b0, 1'b0));
    pinChk(1'b1);
    conv(pick(side));
    rdChk(view(cfg, 1'b1, hi, lo));
    pinChk(1'b0);
    conv(pick(1));
    rdChk(view(cfg, 1'b1, 1'b0, 1'b0));
    pinChk(1'b1);
  endtask

  task automatic testDone();
    if (fails == 0 && nCompared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ----
  // main sequence
  // ----
  initial begin
    logic [15:0] v;
    int fc;
    void'($urandom(32'h0717ac03));
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    rdChk(16'hc810);
    // ready flag: set, cleared by read, kept by shutdown write, cleared by others
    conv(pick(1));
    rdChk(view(16'hc810, 1'b1, 1'b0, 1'b0));
    rdChk(view(16'hc810, 1'b0, 1'b0, 1'b0));
    conv(pick(1));
    host.wr(16'hc810);
    rdChk(view(16'hc810, 1'b1, 1'b0, 1'b0));
    conv(pick(1));
    host.wr(16'hcc10);
    rdChk(view(16'hcc10, 1'b0, 1'b0, 1'b0));
    // every fault-count code, both thresholds, transparent style
    for (fc = 0; fc < 4; fc++) begin
      host.wr({14'h3300, 2'(fc)});
      faultRun({14'h3300, 2'(fc)}, 2);
      faultRun({14'h3300, 2'(fc)}, 0);
    end
    // latched style holds until a read clears it
    host.wr(16'hcc10);
    conv(pick(2));
    conv(pick(1));
    pinChk(1'b0);
    rdChk(view(16'hcc10, 1'b1, 1'b1, 1'b0));
    pinChk(1'b1);
    rdChk(view(16'hcc10, 1'b0, 1'b0, 1'b0));
    // inverted polarity releases the pin on an event
    host.wr(16'hcc08);
    conv(pick(1));
    pinChk(1'b0);
    conv(pick(0));
    pinChk(1'b1);
    // high limit just under every unmasked above-value, so a masked compare would miss;
    // low limit keeps its level under another exponent
    @(posedge clock);
    highLimit <= 16'h0fff;
    lowLimit <= 16'h3020;
    // manual range with mask: exponent hidden, compare still on the full value
    host.wr(16'h3c04);
    v = pick(2);
    conv(v);
    #1;
    chk(resultOut, {4'h0, v[11:0]});
    chk({11'h0, convTimeOut, rangeOut}, 16'h0013);
    rdChk(view(16'h3c04, 1'b1, luxOf(v) > luxOf(highLimit), 1'b0));
    // automatic range ignores the mask; mode 11 keeps converting
    host.wr(16'hce04);
    v = pick(2);
    conv(v);
    #1;
    chk(resultOut, v);
    chk({14'h0, modeOut}, 16'h0003);
    // single shot falls back to shutdown and keeps the flags
    host.wr(16'hca10);
    conv(pick(2));
    #1;
    chk({14'h0, modeOut}, 16'h0000);
    rdChk(view(16'hc810, 1'b1, 1'b1, 1'b0));
    testDone();
  end

  // watchdog far beyond the roughly 300 cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    testDone();
  end
endmodule // tb_light_sensor_alert_config
`default_nettype wire
